// ===== rtr_params.svh
// Constants for the reset type recorder
`ifndef RTR_PARAMS_SVH
`define RTR_PARAMS_SVH
`define RTR_RST_NONE     2'h0
`define RTR_RST_CORE     2'h1
`define RTR_RST_CHIP     2'h2
`define RTR_RST_SYS      2'h3
`define RTR_MIN_HOLD     8
`define RTR_POR_CYCLES   8
`define RTR_REQ_TAIL     2
`endif

// ===== rtr_pkg.sv
// Types for the reset type recorder
package rtr_pkg;
    typedef enum logic [1:0] {RTR_IDLE, RTR_WAIT, RTR_TAIL} rtr_req_state_t;
endpackage

// ===== rtr_req_ch.sv
// One reset-request channel: set by a trigger, held until tail after input
`timescale 1ns/1ps
`include "rtr_params.svh"
module rtr_req_ch
    import rtr_pkg::*;
(
    input  wire logic clk,      // Processor clock
    input  wire logic reset_n,  // Async reset, active low
    input  wire logic trigger,  // One-cycle request cause
    input  wire logic rst_in,   // Matching reset input level
    output logic      request   // Request output, registered
);
    rtr_req_state_t state_reg;
    rtr_req_state_t state_next;
    logic [1:0]     cnt_reg;
    logic [1:0]     cnt_next;
    logic           req_next;

    // Next state of the request channel
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        req_next   = request;
        case (state_reg)
            RTR_IDLE:
            begin
                if (trigger)
                begin
                    state_next = RTR_WAIT;
                    req_next   = 1'b1;
                end
            end
            RTR_WAIT:
            begin
                if (rst_in)
                begin
                    state_next = RTR_TAIL;
                    cnt_next   = 2'h1;
                end
            end
            RTR_TAIL:
            begin
                if (cnt_reg == 2'(`RTR_REQ_TAIL)) // RL11
                begin
                    // A new cause on the drop edge wins over the clear
                    if (trigger)
                    begin
                        state_next = RTR_WAIT;
                    end
                    else
                    begin
                        state_next = RTR_IDLE;
                        req_next   = 1'b0;
                    end
                end
                else
                begin
                    cnt_next = cnt_reg + 2'h1;
                end
            end
            default:
            begin
                state_next = RTR_IDLE;
                req_next   = 1'b0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= RTR_IDLE;
            cnt_reg   <= 2'h0;
            request   <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            request   <= req_next;
        end
    end

    // Request lasts until two cycles after the input is seen
    property p_req_hold;
        @(posedge clk) disable iff (!reset_n)
        (request && !rst_in) |=> request || $past(rst_in);
    endproperty
    a_req_hold: assert property (p_req_hold) // RL11
        else $error("request dropped before input");

    property p_req_drop;
        @(posedge clk) disable iff (!reset_n)
        (state_reg == RTR_WAIT && rst_in)
        |=> request ##1 request ##1 (!request || $past(trigger));
    endproperty
    a_req_drop: assert property (p_req_drop) // RL11
        else $error("request tail length wrong");
endmodule

// ===== rtr_top.sv
// Reset type recorder: power-on, core reset, type field and requests
`timescale 1ns/1ps
`include "rtr_params.svh"
// Function
// RL1: Separate core, chip, system inputs; latest type kept in status field.
// RL2: Any reset during operation halts execution and loses processor state.
// RL3: Core reset reinitialises execution, caches and memory controller only.
// RL4: Requests are outputs only; reset activity needs an external input.
// RL5: Outside logic drives reset inputs synchronous to the clock.
// RL6: Outside logic holds asserted reset inputs at least eight cycles.
// RL7: Valid sets: core; core and chip; core, chip and system.
// RL8: Field: none keeps, core 01, chip 10, system or power-on 11.
// RL9: Power-on asserts all reset inputs and test reset eight cycles.
// RL10: Outside logic may support fewer reset types.
// RL11: A request holds until two cycles after its input is asserted.
// RL12: Debug field or watchdog timeout value 1,2,3 raises that request.
// RL13: Chip only marks type; system also resets test-access unit.
// RL14: Test-access reset input is active low.
// RL15: Field updates from inputs seen while core input held.
module rtr_top
    import rtr_pkg::*;
#(
    parameter int POR_CYCLES = `RTR_POR_CYCLES  // Power-on hold length
)
(
    input  wire logic       clk,                   // Processor clock
    input  wire logic       reset_n,               // Power-on reset, low
    input  wire logic       core_reset_in,         // Core reset input
    input  wire logic       chip_reset_in,         // Chip reset type mark
    input  wire logic       system_reset_in,       // System reset type mark
    input  wire logic       test_access_reset_n,   // Test reset, low
    input  wire logic [1:0] debug_reset_field,     // Debug control value
    input  wire logic       debug_reset_write,     // Debug field write pulse
    input  wire logic [1:0] watchdog_reset_field,  // Watchdog reset value
    input  wire logic       watchdog_timeout,      // Watchdog timeout pulse
    output logic            core_logic_reset,      // Core, caches, mem ctrl
    output logic            test_access_unit_reset,// Test-access unit reset
    output logic            run_enable,            // Execution allowed
    output logic [1:0]      most_recent_reset_field, // Last reset type
    output logic            core_reset_request,    // Core reset request
    output logic            chip_reset_request,    // Chip reset request
    output logic            system_reset_request   // System reset request
);
    initial
    begin
        if (POR_CYCLES < `RTR_POR_CYCLES || POR_CYCLES > 255)
            $error("POR_CYCLES out of range");
    end

    logic [7:0] por_cnt_reg;
    logic [7:0] por_cnt_next;
    logic       por_act;
    logic       core_eff;
    logic       chip_eff;
    logic       sys_eff;
    logic       trst_eff;
    logic [1:0] typ_next;
    logic [2:0] trig;

    // Decode a 2-bit request value into one-hot request causes
    function automatic logic [2:0] rtr_dec(input logic [1:0] v);
        rtr_dec = {v == `RTR_RST_SYS, v == `RTR_RST_CHIP, v == `RTR_RST_CORE};
    endfunction

    // Power-on counter drives internal copies of all reset inputs
    always_comb
    begin
        por_act      = por_cnt_reg != 8'h00;
        por_cnt_next = por_act ? por_cnt_reg - 8'h01 : por_cnt_reg;
        core_eff     = core_reset_in | por_act;          // RL9
        chip_eff     = chip_reset_in | por_act;          // RL9
        sys_eff      = system_reset_in | por_act;        // RL9
        trst_eff     = !test_access_reset_n | por_act;   // RL14 RL9
    end

    // Type field from the combination seen under core reset
    always_comb
    begin
        typ_next = most_recent_reset_field;
        if (core_eff) // RL15
        begin
            if (sys_eff)
                typ_next = `RTR_RST_SYS;   // RL8
            else if (chip_eff)
                typ_next = `RTR_RST_CHIP;  // RL8
            else
                typ_next = `RTR_RST_CORE;  // RL8 RL1
        end
    end

    // Power-on state and registered outputs
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            por_cnt_reg             <= 8'(POR_CYCLES);
            core_logic_reset        <= 1'b1;
            test_access_unit_reset  <= 1'b1;
            run_enable              <= 1'b0;
            most_recent_reset_field <= `RTR_RST_SYS;
        end
        else
        begin
            por_cnt_reg             <= por_cnt_next;
            core_logic_reset        <= core_eff;            // RL3 RL13
            test_access_unit_reset  <= sys_eff | trst_eff;  // RL13
            run_enable              <= !core_eff;           // RL2
            most_recent_reset_field <= typ_next;            // RL1
        end
    end

    // Request causes, never fed back into reset activity
    always_comb
    begin
        trig = (debug_reset_write ? rtr_dec(debug_reset_field) : 3'h0)
             | (watchdog_timeout ? rtr_dec(watchdog_reset_field) : 3'h0);
    end                                                    // RL12 RL4

    rtr_req_ch u_core_req
    (
        .clk     (clk),
        .reset_n (reset_n),
        .trigger (trig[0]),
        .rst_in  (core_reset_in),
        .request (core_reset_request)
    );
    rtr_req_ch u_chip_req
    (
        .clk     (clk),
        .reset_n (reset_n),
        .trigger (trig[1]),
        .rst_in  (chip_reset_in),
        .request (chip_reset_request)
    );
    rtr_req_ch u_sys_req
    (
        .clk     (clk),
        .reset_n (reset_n),
        .trigger (trig[2]),
        .rst_in  (system_reset_in),
        .request (system_reset_request)
    );

    // Checks
    property p_core_halt;
        @(posedge clk) disable iff (!reset_n)
        core_reset_in |=> core_logic_reset && !run_enable;
    endproperty
    a_core_halt: assert property (p_core_halt) // RL2
        else $error("core reset did not halt");

    property p_chip_only;
        @(posedge clk) disable iff (!reset_n)
        (chip_reset_in && !core_reset_in && !por_act) |=> !core_logic_reset;
    endproperty
    a_chip_only: assert property (p_chip_only) // RL13
        else $error("chip alone reset the core");

    property p_typ_keep;
        @(posedge clk) disable iff (!reset_n)
        !core_eff |=> $stable(most_recent_reset_field);
    endproperty
    a_typ_keep: assert property (p_typ_keep) // RL15
        else $error("field changed without core reset");

    property p_typ_core;
        @(posedge clk) disable iff (!reset_n)
        (core_reset_in && !chip_reset_in && !system_reset_in && !por_act)
        |=> most_recent_reset_field == 2'h1;
    endproperty
    a_typ_core: assert property (p_typ_core) // RL8
        else $error("core type not recorded");

    property p_typ_sys;
        @(posedge clk) disable iff (!reset_n)
        (core_reset_in && system_reset_in) |=> most_recent_reset_field == 2'h3;
    endproperty
    a_typ_sys: assert property (p_typ_sys) // RL8
        else $error("system type not recorded");

    property p_por_hold;
        @(posedge clk) disable iff (!reset_n)
        $rose(reset_n) |-> core_logic_reset [*8];
    endproperty
    a_por_hold: assert property (p_por_hold) // RL9
        else $error("power-on reset too short");

    property p_trst;
        @(posedge clk) disable iff (!reset_n)
        !test_access_reset_n |=> test_access_unit_reset;
    endproperty
    a_trst: assert property (p_trst) // RL14
        else $error("test reset ignored");

    property p_req_no_self;
        @(posedge clk) disable iff (!reset_n)
        (core_reset_request && !core_reset_in && !por_act)
        |=> !core_logic_reset;
    endproperty
    a_req_no_self: assert property (p_req_no_self) // RL4
        else $error("request caused reset");
endmodule

// ===== rtr_fabric_model.sv
// Fabric reset generator answering requests or bench commands
`timescale 1ns/1ps
module rtr_fabric_model
(
    input  wire logic       clk,      // Processor clock
    input  wire logic       reset_n,  // Async reset, active low
    input  wire logic [2:0] req_vec,  // System, chip, core requests
    input  wire logic       go,       // Bench command pulse
    input  wire logic [1:0] typ,      // 0 bad, 1 core, 2 chip, 3 system
    input  wire logic [3:0] dly,      // Response delay
    input  wire logic [3:0] xh,       // Hold beyond minimum
    output logic            core_o,   // Core reset input
    output logic            chip_o,   // Chip reset input
    output logic            sys_o     // System reset input
);
    logic [1:0] kind;
    int         wcnt;
    int         hcnt;
    // Wait, then hold the combination at falling edges
    always @(negedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {core_o, chip_o, sys_o} <= 3'h0;
            wcnt <= 0;
            hcnt <= 0;
            kind <= 2'h1;
        end
        else if (hcnt > 1)
            hcnt <= hcnt - 1;
        else if (hcnt == 1)
        begin
            hcnt <= 0;
            {core_o, chip_o, sys_o} <= 3'h0;
        end
        else if (wcnt > 1)
            wcnt <= wcnt - 1;
        else if (wcnt == 1)
        begin
            wcnt <= 0;
            hcnt <= 8 + xh;
            core_o <= kind != 0;
            chip_o <= kind != 1;
            sys_o <= kind == 3 || kind == 0;
        end
        else if (go || req_vec != 0)
        begin
            kind <= go ? typ : req_vec[2] ? 2'h3 : req_vec[1] ? 2'h2 : 2'h1;
            wcnt <= dly + 1;
        end
    end
endmodule

// ===== rtr_top_bench.sv
// Bench for the reset type recorder with fabric model
`timescale 1ns/1ps
module rtr_top_bench;
    logic       clk = 0;
    logic       reset_n = 0;
    logic       tr_n = 1;
    logic [1:0] dbg_v = 0;
    logic       dbg_w = 0;
    logic [1:0] wd_v = 0;
    logic       wd_t = 0;
    logic       go = 0;
    logic [1:0] typ = 1;
    logic [3:0] dly = 0;
    logic [3:0] xh = 0;
    logic [1:0] t;
    logic       clr, tar, run;
    logic [1:0] fld;
    wire  [2:0] req;
    wire        cr, chr, sr;
    int         num_errors = 0;
    int         comparisons = 0;
    // Clock at 100 MHz
    always #5 clk = ~clk;
    rtr_fabric_model fab (.clk(clk), .reset_n(reset_n), .req_vec(req),
        .go(go), .typ(typ), .dly(dly), .xh(xh), .core_o(cr),
        .chip_o(chr), .sys_o(sr));
    rtr_top DUT (.clk(clk), .reset_n(reset_n), .core_reset_in(cr),
        .chip_reset_in(chr), .system_reset_in(sr),
        .test_access_reset_n(tr_n), .debug_reset_field(dbg_v),
        .debug_reset_write(dbg_w), .watchdog_reset_field(wd_v),
        .watchdog_timeout(wd_t), .core_logic_reset(clr),
        .test_access_unit_reset(tar), .run_enable(run),
        .most_recent_reset_field(fld), .core_reset_request(req[0]),
        .chip_reset_request(req[1]), .system_reset_request(req[2]));
    task automatic finish_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
        #1;
    endtask
    task automatic wait_core(input logic lvl);
        int i;
        i = 0;
        while (cr !== lvl && i < 60)
        begin
            tick(1);
            i++;
        end
        chk(i < 60, 1);
    endtask
    // Follow one reset from input rise to release
    task automatic hold_chk(input logic [1:0] k, input logic [2:0] rq);
        wait_core(1);
        tick(2);
        chk(req, rq);
        chk(fld, k);
        chk({clr, run, tar}, {2'b10, k == 3});
        tick(2);
        chk(req, 0);
        wait_core(0);
        tick(2);
        chk({fld, clr, run}, {k, 2'b01});
    endtask
    // Debug write or watchdog timeout pulse
    task automatic trig(input logic src, input logic [1:0] v);
        if (src)
        begin
            wd_v = v;
            wd_t = 1;
        end
        else
        begin
            dbg_v = v;
            dbg_w = 1;
        end
        tick(1);
        if (src)
            wd_t = 0;
        else
            dbg_w = 0;
        chk(req, v == 0 ? 3'h0 : 3'h1 << (v - 1));
        chk(clr, 0);
    endtask
    // Watchdog
    initial
    begin
        #50us;
        num_errors++;
        finish_test();
    end
    // Main sequence
    initial
    begin
        dly = 4'($urandom(32'h112b));
        tick(16);
        chk({clr, tar, run, fld, req}, 8'hd8);
        reset_n = 1;
        tick(8);
        chk({clr, run, fld}, 4'hb);
        tick(1);
        chk({clr, run}, 2'b01);
        trig(0, 0);
        trig(1, 0);
        // Descending so the field holds core type before the bad combo
        for (int v = 3; v > 0; v--)
        begin
            typ = 2'(v);
            go = 1;
            tick(1);
            go = 0;
            hold_chk(2'(v), 0);
            trig(v[0], 2'(v));
            hold_chk(2'(v), 3'(1 << (v - 1)));
        end
        typ = 0;
        dly = 0;
        go = 1;
        tick(1);
        go = 0;
        tick(4);
        chk({fld, clr, run, tar}, 8'h0b);
        tick(14);
        tr_n = 0;
        tick(2);
        chk(tar, 1);
        tr_n = 1;
        tick(2);
        chk({tar, clr}, 0);
        repeat (10)
        begin
            t = 2'($urandom_range(3, 1));
            dly = 4'($urandom);
            xh = 4'($urandom);
            trig(1'($urandom_range(1, 0)), t);
            hold_chk(t, 3'h1 << (t - 1));
        end
        finish_test();
    end
endmodule
